// *** logic/dcr_pkg.sv ***
// Package: register map, field layout and types of the channel configuration register slice
package dcr_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [6:0] ADDR_STREAM_LEN    = 7'h0e;
  localparam logic [6:0] ADDR_IFACE_CFG_C   = 7'h10;
  localparam logic [6:0] ADDR_IFACE_STATUS  = 7'h11;
  localparam logic [6:0] ADDR_CHAN_ENABLES  = 7'h14;
  localparam logic [6:0] ADDR_CHAN0_RANGE   = 7'h15;
  localparam logic [6:0] ADDR_FIRST         = 7'h00;
  localparam logic [6:0] ADDR_LAST          = 7'h7f;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_STREAM_LEN     = 8'h00;
  localparam logic [7:0] RST_IFACE_CFG_C    = 8'h20;
  localparam logic [7:0] RST_CHAN_ENABLES   = 8'h80;
  localparam logic [7:0] RST_CHAN0_RANGE    = 8'h00;

  // ==========================================================
  // Field positions and masks
  localparam int         BIT_SINK_EN        = 7;
  localparam int         BIT_NOT_READY      = 7;
  localparam int         BIT_STRICT         = 5;
  localparam logic [7:0] MASK_CHAN_ENABLES  = 8'hbf;
  localparam int         NUM_CHAN           = 6;

  // Channel 0 range modes
  typedef enum logic [1:0] {
    DCR_RANGE_SOURCE = 2'h0,
    DCR_RANGE_SINK   = 2'h1,
    DCR_RANGE_BOTH   = 2'h2,
    DCR_RANGE_RSVD   = 2'h3
  } dcr_range_t;

  // Channel 0 range register layout
  typedef struct packed {
    logic [5:0] scale;
    dcr_range_t mode;
  } dcr_range_reg_t;

  // Register access request from the serial framer
  typedef struct packed {
    logic       start;
    logic       write;
    logic       read;
    logic [6:0] addr;
    logic [7:0] wdata;
  } dcr_req_t;

  // Streaming controls from the interface configuration registers
  typedef struct packed {
    logic no_streaming;
    logic ascend;
  } dcr_stream_cfg_t;

endpackage : dcr_pkg

// *** logic/dcr_addr_step.sv ***
// Streaming address stepper: computes each next register address in a stream
`timescale 1ns/1ps
module dcr_addr_step #(
  parameter int AW = 7
) (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst,
  // Stream control
  input  wire logic                     start,
  input  wire logic [AW-1:0]            start_addr,
  input  wire logic                     step,
  input  wire dcr_pkg::dcr_stream_cfg_t cfg,
  input  wire logic [7:0]               stream_len,
  // Current address
  output logic      [AW-1:0]            addr
);

  // ==========================================================
  // Address state
  logic [AW-1:0] addr_reg;
  logic [AW-1:0] addr_next;
  logic [AW-1:0] first_reg;
  logic [AW-1:0] first_next;
  logic [7:0]    count_reg;
  logic [7:0]    count_next;
  logic [AW-1:0] base_addr;
  logic [7:0]    base_count;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] a, input logic up);
    bump = up ? AW'(a + 1'b1) : AW'(a - 1'b1);
  endfunction : bump

  always_comb begin
    // A start byte is itself an access: stepping from the framed address keeps
    // the second byte of a stream off the address the first one used, except at stream length 1
    base_addr  = start ? start_addr : addr_reg;
    first_next = start ? start_addr : first_reg;
    base_count = start ? 8'h00 : count_reg;
    addr_next  = base_addr;
    count_next = base_count;
    if (step && !cfg.no_streaming) begin
      if (stream_len != 8'h00 && base_count == 8'(stream_len - 8'h01)) begin
        addr_next  = first_next;
        count_next = 8'h00;
      end else if (stream_len == 8'h00 && cfg.ascend && base_addr == dcr_pkg::ADDR_LAST) begin
        addr_next = dcr_pkg::ADDR_FIRST;
      end else if (stream_len == 8'h00 && !cfg.ascend && base_addr == dcr_pkg::ADDR_FIRST) begin
        addr_next = dcr_pkg::ADDR_LAST;
      end else begin
        addr_next  = bump(base_addr, cfg.ascend);
        count_next = 8'(base_count + 8'h01);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      addr_reg  <= '0;
      first_reg <= '0;
      count_reg <= 8'h00;
    end else begin
      addr_reg  <= addr_next;
      first_reg <= first_next;
      count_reg <= count_next;
    end
  end

  assign addr = addr_reg;

endmodule : dcr_addr_step

// *** logic/dcr_regs.sv ***
// Channel configuration register slice clocked by the serial clock
// ==========================================================
// Summary of operation
// - Nonzero stream length: step that many addresses, then return to stream start.
// - Zero stream length: step to end of space, wrap, continue same direction.
// - Busy flag at status bit 7 is set while data cannot be accepted; resets 0.
// - Enables bit 7 turns the channel 0 sink generator on; resets to 1.
// - Enables bits 5..0 are active-low shutdowns of channels 5..0; reset 0.
// - Range bits 7:2 hold channel 0 scaling factor; reset zero.
// - Range bits 1:0 pick source-only, sink-only or both for channel 0.
// - Mirrored ascension bits: set increments, clear decrements streaming addresses.
// - Single-instruction bit disables streaming; bytes after the start byte stay on the framed address.
`timescale 1ns/1ps
module dcr_regs #(
  parameter int AW = 7
) (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst,
  // Access from the serial framer
  input  wire dcr_pkg::dcr_req_t        req,
  input  wire dcr_pkg::dcr_stream_cfg_t stream_cfg,
  input  wire logic                     core_busy,
  output logic      [7:0]               rdata,
  output logic                          rdata_hit,
  output logic      [AW-1:0]            cur_addr,
  // Analog controls
  output logic                          chan0_sink_enable,
  output logic      [dcr_pkg::NUM_CHAN-1:0] chan_output_on,
  output logic      [5:0]               chan0_scale_factor,
  output dcr_pkg::dcr_range_t           chan0_range_select
);

  // ==========================================================
  // Address stepping
  logic [7:0] stream_len_reg;
  logic [7:0] stream_len_next;
  logic       access;

  assign access = req.write | req.read;

  dcr_addr_step #(.AW(AW)) u_step (
    .clock      (clock),
    .rst        (rst),
    .start      (req.start),
    .start_addr (req.addr),
    .step       (access),
    .cfg        (stream_cfg),
    .stream_len (stream_len_reg),
    .addr       (cur_addr)
  );

  // Start cycle uses the framed address, later bytes the stepped one
  logic [AW-1:0] eff_addr;
  assign eff_addr = req.start ? req.addr : cur_addr;

  // ==========================================================
  // Registers
  logic [7:0]               chan_en_reg;
  logic [7:0]               chan_en_next;
  dcr_pkg::dcr_range_reg_t  range_reg;
  dcr_pkg::dcr_range_reg_t  range_next;
  logic                     busy_reg;
  logic                     busy_next;
  logic [7:0]               rdata_reg;
  logic [7:0]               rdata_next;
  logic                     hit_reg;
  logic                     hit_next;
  logic [7:0]               status_val;
  logic [7:0]               cfg_c_val;

  always_comb begin
    status_val = 8'h00;
    status_val[dcr_pkg::BIT_NOT_READY] = busy_reg;
    cfg_c_val = dcr_pkg::RST_IFACE_CFG_C;
  end

  always_comb begin
    stream_len_next = stream_len_reg;
    chan_en_next    = chan_en_reg;
    range_next      = range_reg;
    // Busy tracks the core; writes while busy are dropped
    busy_next       = core_busy;
    rdata_next      = rdata_reg;
    hit_next        = 1'b0;
    if (req.write && !busy_reg) begin
      case (eff_addr)
        dcr_pkg::ADDR_STREAM_LEN:   stream_len_next = req.wdata;
        dcr_pkg::ADDR_CHAN_ENABLES: chan_en_next = req.wdata & dcr_pkg::MASK_CHAN_ENABLES;
        dcr_pkg::ADDR_CHAN0_RANGE:  range_next = req.wdata;
        default: ;
      endcase
    end
    if (req.read) begin
      hit_next = 1'b1;
      case (eff_addr)
        dcr_pkg::ADDR_STREAM_LEN:   rdata_next = stream_len_reg;
        dcr_pkg::ADDR_IFACE_CFG_C:  rdata_next = cfg_c_val;
        dcr_pkg::ADDR_IFACE_STATUS: rdata_next = status_val;
        dcr_pkg::ADDR_CHAN_ENABLES: rdata_next = chan_en_reg;
        dcr_pkg::ADDR_CHAN0_RANGE:  rdata_next = range_reg;
        default: begin
          rdata_next = 8'h00;
          hit_next   = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      stream_len_reg <= dcr_pkg::RST_STREAM_LEN;
      chan_en_reg    <= dcr_pkg::RST_CHAN_ENABLES;
      range_reg      <= dcr_pkg::RST_CHAN0_RANGE;
      busy_reg       <= 1'b0;
      rdata_reg      <= 8'h00;
      hit_reg        <= 1'b0;
    end else begin
      stream_len_reg <= stream_len_next;
      chan_en_reg    <= chan_en_next;
      range_reg      <= range_next;
      busy_reg       <= busy_next;
      rdata_reg      <= rdata_next;
      hit_reg        <= hit_next;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata              = rdata_reg;
  assign rdata_hit          = hit_reg;
  assign chan0_sink_enable  = chan_en_reg[dcr_pkg::BIT_SINK_EN];
  assign chan_output_on     = chan_en_reg[dcr_pkg::NUM_CHAN-1:0];
  assign chan0_scale_factor = range_reg.scale;
  assign chan0_range_select = range_reg.mode;

  // ==========================================================
  // Checks
  property p_busy_follows;
    @(posedge clock) disable iff (rst)
    core_busy |=> (status_val[dcr_pkg::BIT_NOT_READY] == 1'b1);
  endproperty
  a_busy_follows: assert property (p_busy_follows) else $error("busy flag missed");

  property p_write_range;
    @(posedge clock) disable iff (rst)
    (req.write && !busy_reg && eff_addr == dcr_pkg::ADDR_CHAN0_RANGE)
      |=> (chan0_scale_factor == $past(req.wdata[7:2])
        && chan0_range_select == $past(req.wdata[1:0]));
  endproperty
  a_write_range: assert property (p_write_range) else $error("range write lost");

  property p_enables;
    @(posedge clock) disable iff (rst)
    (req.write && !busy_reg && eff_addr == dcr_pkg::ADDR_CHAN_ENABLES)
      |=> (chan_output_on == $past(req.wdata[5:0]) && chan0_sink_enable == $past(req.wdata[7]));
  endproperty
  a_enables: assert property (p_enables) else $error("enable write lost");

  property p_busy_blocks;
    @(posedge clock) disable iff (rst)
    (req.write && busy_reg) |=> $stable(chan_en_reg) && $stable(range_reg);
  endproperty
  a_busy_blocks: assert property (p_busy_blocks) else $error("write taken while busy");

  property p_strict;
    @(posedge clock) disable iff (rst)
    1'b1 ##1 (req.read && eff_addr == dcr_pkg::ADDR_IFACE_CFG_C)
      |=> rdata[dcr_pkg::BIT_STRICT];
  endproperty
  a_strict: assert property (p_strict) else $error("strict bit not set");

  property p_no_stream;
    @(posedge clock) disable iff (rst)
    (access && stream_cfg.no_streaming) |=> cur_addr == $past(eff_addr);
  endproperty
  a_no_stream: assert property (p_no_stream) else $error("address stepped");

  property p_ascend;
    @(posedge clock) disable iff (rst)
    (access && !stream_cfg.no_streaming && stream_len_reg == 8'h00
      && stream_cfg.ascend && eff_addr != dcr_pkg::ADDR_LAST)
      |=> cur_addr == AW'($past(eff_addr) + 1'b1);
  endproperty
  a_ascend: assert property (p_ascend) else $error("ascend step wrong");

  property p_wrap;
    @(posedge clock) disable iff (rst)
    (access && !stream_cfg.no_streaming && stream_len_reg == 8'h00
      && !stream_cfg.ascend && eff_addr == dcr_pkg::ADDR_FIRST)
      |=> cur_addr == dcr_pkg::ADDR_LAST;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap wrong");

  property p_loop;
    @(posedge clock) disable iff (rst)
    (req.start && stream_len_reg == 8'h01 && !stream_cfg.no_streaming)
      ##1 (access && !req.start && $stable(stream_len_reg))
      |=> cur_addr == $past(cur_addr);
  endproperty
  a_loop: assert property (p_loop) else $error("stream loop wrong");

  // The status read shows the busy input as it stood two edges earlier
  property p_busy_read;
    @(posedge clock) disable iff (rst)
    (req.read && eff_addr == dcr_pkg::ADDR_IFACE_STATUS)
      |=> rdata[dcr_pkg::BIT_NOT_READY] == $past(core_busy, 2);
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy flag not read back");

  // Read data is registered, so it must match the register as it stood at the read edge
  property p_read_range;
    @(posedge clock) disable iff (rst)
    (req.read && eff_addr == dcr_pkg::ADDR_CHAN0_RANGE)
      |=> (rdata_hit && rdata == $past(range_reg));
  endproperty
  a_read_range: assert property (p_read_range) else $error("range readback wrong");

  property p_reset_values;
    @(posedge clock)
    $fell(rst) |-> (chan_en_reg == dcr_pkg::RST_CHAN_ENABLES
      && range_reg == dcr_pkg::RST_CHAN0_RANGE);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset value wrong");

endmodule : dcr_regs

// *** bench/dcr_host_model.sv ***
// Host model: issues one register access byte per clock
`timescale 1ns/1ps
module dcr_host_model (
  // Clock
  input  wire logic         clock,
  // Access request
  output dcr_pkg::dcr_req_t req
);
  initial req = '0;
  // ==========================================================
  // Byte access; strobes stay up until the next call or idle
  // Multibyte orders are the caller's job: bytes go out in call order
  task automatic op(input logic s, input logic w, input logic [6:0] a,
                    input logic [7:0] d);
    @(posedge clock);
    req <= '{start: s, write: w, read: !w, addr: a, wdata: d};
  endtask : op
  // ==========================================================
  // Released data lines show the inverse of the last value
  task automatic idle();
    @(posedge clock);
    req <= '{start: 1'b0, write: 1'b0, read: 1'b0, addr: ~req.addr, wdata: ~req.wdata};
  endtask : idle
endmodule : dcr_host_model

// *** bench/dcr_regs_bench.sv ***
// Testbench for the channel configuration register slice
`timescale 1ns/1ps
module dcr_regs_bench;
  // ==========================================================
  // Stimulus and observed signals
  logic                     clock = 1'b0;
  logic                     rst = 1'b1;
  logic                     core_busy = 1'b0;
  dcr_pkg::dcr_stream_cfg_t stream_cfg = '{no_streaming: 1'b0, ascend: 1'b1};
  dcr_pkg::dcr_req_t        req;
  logic [7:0]               rdata;
  logic                     rdata_hit;
  logic [6:0]               cur_addr;
  logic                     sink;
  logic [5:0]               on;
  logic [5:0]               scale;
  dcr_pkg::dcr_range_t      mode;
  int                       fails = 0;
  int                       n_checks = 0;
  int                       cycles = 0;

  always #4 clock = ~clock;

  dcr_host_model host (.clock(clock), .req(req));
  dcr_regs #(.AW(7)) uut (.clock(clock), .rst(rst), .req(req), .stream_cfg(stream_cfg),
    .core_busy(core_busy), .rdata(rdata), .rdata_hit(rdata_hit), .cur_addr(cur_addr),
    .chan0_sink_enable(sink), .chan_output_on(on), .chan0_scale_factor(scale),
    .chan0_range_select(mode));

  // ==========================================================
  // Shared helpers
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.op(1'b1, 1'b1, a, d);
    host.idle();
    #1;
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] exp, input logic hit);
    host.op(1'b1, 1'b0, a, 8'h00);
    host.idle();
    #1;
    chk("rdata", rdata, exp);
    chk("rdata_hit", {7'h00, rdata_hit}, {7'h00, hit});
  endtask : rd
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd(7'h0e, 8'h00, 1'b1);
    rd(7'h10, 8'h20, 1'b1);
    rd(7'h11, 8'h00, 1'b1);
    rd(7'h14, 8'h80, 1'b1);
    rd(7'h15, 8'h00, 1'b1);
    rd(7'h7e, 8'h00, 1'b0);
    chk("sink", {7'h00, sink}, 8'h01);
    chk("on", {2'h0, on}, 8'h00);
  endtask : t_reset
  task automatic t_enables();
    wr(7'h14, 8'h3f);
    chk("sink", {7'h00, sink}, 8'h00);
    chk("on", {2'h0, on}, 8'h3f);
    wr(7'h14, 8'hff);
    rd(7'h14, 8'hbf, 1'b1);
    wr(7'h14, 8'h15);
    chk("on", {2'h0, on}, 8'h15);
    wr(7'h10, 8'h00);
    rd(7'h10, 8'h20, 1'b1);
    wr(7'h11, 8'hff);
    rd(7'h11, 8'h00, 1'b1);
  endtask : t_enables
  task automatic t_range();
    for (int m = 0; m < 3; m++) begin
      wr(7'h15, {6'h00, m[1:0]});
      chk("mode", {6'h00, mode}, {6'h00, m[1:0]});
    end
    wr(7'h15, 8'ha8);
    chk("scale", {2'h0, scale}, 8'h2a);
    rd(7'h15, 8'ha8, 1'b1);
  endtask : t_range
  task automatic t_busy();
    @(posedge clock) core_busy <= 1'b1;
    repeat (2) @(posedge clock);
    rd(7'h11, 8'h80, 1'b1);
    wr(7'h14, 8'h01);
    chk("on", {2'h0, on}, 8'h15);
    @(posedge clock) core_busy <= 1'b0;
    repeat (2) @(posedge clock);
    rd(7'h11, 8'h00, 1'b1);
    wr(7'h14, 8'h01);
    chk("on", {2'h0, on}, 8'h01);
  endtask : t_busy
  task automatic t_stream();
    // Length 2: the third byte lands back on the first address
    wr(7'h0e, 8'h02);
    host.op(1'b1, 1'b1, 7'h14, 8'h3f);
    host.op(1'b0, 1'b1, 7'h00, 8'h28);
    host.op(1'b0, 1'b1, 7'h00, 8'h02);
    host.idle();
    #1;
    chk("on", {2'h0, on}, 8'h02);
    chk("scale", {2'h0, scale}, 8'h0a);
    wr(7'h0e, 8'h00);
    rd(7'h7f, 8'h00, 1'b0);
    chk("cur_addr", {1'b0, cur_addr}, 8'h00);
    @(posedge clock) stream_cfg <= '{no_streaming: 1'b0, ascend: 1'b0};
    rd(7'h00, 8'h00, 1'b0);
    chk("cur_addr", {1'b0, cur_addr}, 8'h7f);
    rd(7'h15, 8'h28, 1'b1);
    chk("cur_addr", {1'b0, cur_addr}, 8'h14);
    @(posedge clock) stream_cfg <= '{no_streaming: 1'b1, ascend: 1'b1};
    rd(7'h14, 8'h02, 1'b1);
    chk("cur_addr", {1'b0, cur_addr}, 8'h14);
    // A follow-on byte without start must stay on the framed address
    host.op(1'b0, 1'b0, 7'h15, 8'h00);
    host.idle();
    #1;
    chk("rdata", rdata, 8'h02);
    chk("cur_addr", {1'b0, cur_addr}, 8'h14);
    // Length 1: every byte of the stream lands on the start address
    @(posedge clock) stream_cfg <= '{no_streaming: 1'b0, ascend: 1'b1};
    wr(7'h0e, 8'h01);
    host.op(1'b1, 1'b0, 7'h15, 8'h00);
    host.op(1'b0, 1'b0, 7'h00, 8'h00);
    host.idle();
    #1;
    chk("rdata", rdata, 8'h28);
    chk("cur_addr", {1'b0, cur_addr}, 8'h15);
  endtask : t_stream

  // ==========================================================
  // Hang guard, well above the hundred or so cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      wrap_up();
    end
  end

  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_enables();
    t_range();
    t_busy();
    t_stream();
    wrap_up();
  end
endmodule : dcr_regs_bench
